// ### core/nfh_params.svh
// Timing counts, command codes and status bit positions for the NAND host.
// Assumes a 125 MHz system clock; included by the core, the flash model and the bench.
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH
`define NFH_CMD_READ 8'h00
`define NFH_CMD_READ_CONF 8'h30
`define NFH_CMD_SERIAL_IN 8'h80
`define NFH_CMD_COL_CHANGE 8'h85
`define NFH_CMD_PROG_CONF 8'h10
`define NFH_CMD_MULTI_PROG 8'h11
`define NFH_CMD_CACHE_PROG 8'h15
`define NFH_CMD_ERASE1 8'h60
`define NFH_CMD_ERASE2 8'hd0
`define NFH_CMD_STATUS 8'h70
`define NFH_CMD_STATUS_ALT 8'h71
`define NFH_CMD_RESET 8'hff
`define NFH_ST_FAIL 0
`define NFH_ST_READY 6
`define NFH_ST_WP 7
`define NFH_CLK_NS 8
`define NFH_STROBE_NS 32
`define NFH_STROBE_CYC ((`NFH_STROBE_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`endif

// ### core/nfh_pkg.sv
// Types shared by the NAND host core.
// Assumes nfh_params.svh supplies all numeric constants.
package nfh_pkg;
    // Kind of one bus cycle queued by the user
    typedef enum logic [1:0] {NFH_CYC_CMD, NFH_CYC_ADDR, NFH_CYC_WR,
        NFH_CYC_RD} nfh_cyc_t;

    // One user request
    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] data;
    } nfh_req_t;

    // Flash pin bundle driven by the host
    typedef struct packed {
        logic ceN;
        logic cle;
        logic ale;
        logic weN;
        logic reN;
        logic wpN;
        logic [7:0] dataOut;
        logic dataOe;
    } nfh_pins_t;
endpackage

// ### core/nfh_host.sv
// NAND flash host sequencer: drives command, address and data strobes.
// Assumes the flash pins are synchronous to clk; busy line has a pull-up.
`timescale 1ns/1ns
`include "nfh_params.svh"

// Function
// - While flash is busy, host sends only status read or reset; after 70h or 71h it still passes address and write cycles.
// - During initialization host sends only reset or status read; address and write cycles are not held back by initDone.
// - Host never sends command codes outside the defined set.
// - After serial input only 85h, 10h, 11h, 15h or reset follow.
// - Host programs pages of a block in ascending order; left to the software that feeds req.
// - Host checks bad marks in pages one and two, never erases bad; left to the software that feeds req.
// - On program failure host rewrites elsewhere and bars old block; host only raises progFail.
// - Host corrects at least one bit per 512-byte sector; left to the software that feeds req.
module nfh_host (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reqValid,
    input wire nfh_pkg::nfh_req_t req,
    input wire logic writeProtectN,
    input wire logic powerOnSelectStrap,
    input wire logic ready_busy_n,
    input wire logic [7:0] dataIn,
    output logic reqReady,
    output logic reqRefused,
    output logic rdValid,
    output logic [7:0] rdData,
    output logic flashReady,
    output logic progFail,
    output logic initDone,
    output nfh_pkg::nfh_pins_t pins
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD,
        S_WAITBUSY} nfh_state_t;

    typedef struct packed {
        nfh_state_t st;
        logic [3:0] cnt;
        logic [1:0] kind;
        logic inProgSeq;
        logic resetSeen;
        logic lastStatus;
        logic reqReady;
        logic reqRefused;
        logic rdValid;
        logic [7:0] rdData;
        logic flashReady;
        logic progFail;
        logic initDone;
        nfh_pkg::nfh_pins_t pins;
    } nfh_state_s_t;

    nfh_state_s_t s;
    nfh_state_s_t next_s;
    logic legalCode;
    logic busyOk;
    logic seqOk;

    // ------------------------------------------------------------
    // Command checks
    // ------------------------------------------------------------
    // known codes only
    always_comb begin
        unique case (req.data)
            `NFH_CMD_READ, `NFH_CMD_READ_CONF, `NFH_CMD_SERIAL_IN,
            `NFH_CMD_COL_CHANGE, `NFH_CMD_PROG_CONF, `NFH_CMD_MULTI_PROG,
            `NFH_CMD_CACHE_PROG, `NFH_CMD_ERASE1, `NFH_CMD_ERASE2,
            `NFH_CMD_STATUS, `NFH_CMD_STATUS_ALT, `NFH_CMD_RESET:
                legalCode = 1'b1;
            default: legalCode = 1'b0;
        endcase
    end

    assign busyOk = ready_busy_n || req.data == `NFH_CMD_STATUS ||
        req.data == `NFH_CMD_STATUS_ALT || req.data == `NFH_CMD_RESET;

    assign seqOk = !s.inProgSeq || req.data == `NFH_CMD_COL_CHANGE ||
        req.data == `NFH_CMD_PROG_CONF || req.data == `NFH_CMD_MULTI_PROG ||
        req.data == `NFH_CMD_CACHE_PROG || req.data == `NFH_CMD_RESET;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next-state logic for the whole host
    always_comb begin
        next_s = s;
        next_s.reqReady = 1'b0;
        next_s.reqRefused = 1'b0;
        next_s.rdValid = 1'b0;
        next_s.pins.wpN = writeProtectN;
        next_s.flashReady = ready_busy_n;
        unique case (s.st)
            S_IDLE: begin
                next_s.pins.ceN = 1'b0;
                next_s.pins.cle = 1'b0;
                next_s.pins.ale = 1'b0;
                next_s.pins.dataOe = 1'b0;
                // wait for power-up busy to end
                // strap low means init completes on its own
                // strap high waits for a reset command, then ready
                if (!s.initDone && ready_busy_n &&
                    (!powerOnSelectStrap || s.resetSeen)) begin
                    next_s.initDone = 1'b1;
                end
                if (reqValid && !s.reqReady && !s.reqRefused) begin
                    if (req.kind == 2'(nfh_pkg::NFH_CYC_CMD) &&
                        (!legalCode || !busyOk || !seqOk ||
                        // before init only reset or status
                        (!s.initDone && req.data != `NFH_CMD_RESET &&
                        req.data != `NFH_CMD_STATUS &&
                        req.data != `NFH_CMD_STATUS_ALT))) begin
                        next_s.reqRefused = 1'b1;
                    end else if (req.kind != 2'(nfh_pkg::NFH_CYC_CMD) &&
                        !ready_busy_n && !s.lastStatus) begin
                        next_s.st = S_IDLE;
                    end else begin
                        next_s.kind = req.kind;
                        next_s.pins.cle = req.kind == 2'(nfh_pkg::NFH_CYC_CMD);
                        next_s.pins.ale = req.kind == 2'(nfh_pkg::NFH_CYC_ADDR);
                        next_s.pins.dataOut = req.data;
                        next_s.pins.dataOe = req.kind != 2'(nfh_pkg::NFH_CYC_RD);
                        next_s.cnt = 4'(`NFH_STROBE_CYC);
                        next_s.st = S_SETUP;
                        if (req.kind == 2'(nfh_pkg::NFH_CYC_CMD)) begin
                            next_s.inProgSeq = req.data == `NFH_CMD_SERIAL_IN ||
                                req.data == `NFH_CMD_COL_CHANGE;
                            // status mode kept until any other command
                            if (req.data == `NFH_CMD_STATUS ||
                                req.data == `NFH_CMD_STATUS_ALT) begin
                                next_s.lastStatus = 1'b1;
                            end else begin
                                next_s.lastStatus = 1'b0;
                            end
                            // strap high, first reset finishes init
                            if (req.data == `NFH_CMD_RESET) begin
                                next_s.inProgSeq = 1'b0;
                                next_s.resetSeen = 1'b1;
                            end
                        end
                    end
                end
            end
            S_SETUP: begin
                // Assert the strobe for the cycle kind
                if (s.kind == 2'(nfh_pkg::NFH_CYC_RD)) begin
                    next_s.pins.reN = 1'b0;
                end else begin
                    next_s.pins.weN = 1'b0;
                end
                next_s.st = S_STROBE;
            end
            S_STROBE: begin
                if (s.cnt == 4'h0) begin
                    next_s.pins.weN = 1'b1;
                    next_s.pins.reN = 1'b1;
                    if (s.kind == 2'(nfh_pkg::NFH_CYC_RD)) begin
                        // status or page byte captured at end of read strobe
                        next_s.rdData = dataIn;
                        next_s.rdValid = 1'b1;
                        // progFail tells software to move the data
                        // page order, bad marks and correction
                        // are kept by the software that feeds req
                        if (s.lastStatus && dataIn[`NFH_ST_READY]) begin
                            next_s.progFail = dataIn[`NFH_ST_FAIL];
                        end
                    end
                    next_s.cnt = 4'(`NFH_STROBE_CYC);
                    next_s.st = S_HOLD;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            S_HOLD: begin
                if (s.cnt == 4'h0) begin
                    next_s.pins.cle = 1'b0;
                    next_s.pins.ale = 1'b0;
                    next_s.pins.dataOe = 1'b0;
                    next_s.reqReady = 1'b1;
                    next_s.st = S_WAITBUSY;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            S_WAITBUSY: begin
                // a completed reset cycle with the line ready ends the init window
                if (s.kind == 2'(nfh_pkg::NFH_CYC_CMD) &&
                    s.pins.dataOut == `NFH_CMD_RESET && ready_busy_n) begin
                    next_s.initDone = 1'b1;
                end
                next_s.st = S_IDLE;
            end
            default: next_s.st = S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.st <= S_IDLE;
            s.pins.ceN <= 1'b1;
            s.pins.weN <= 1'b1;
            s.pins.reN <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reqReady = s.reqReady;
    assign reqRefused = s.reqRefused;
    assign rdValid = s.rdValid;
    assign rdData = s.rdData;
    assign flashReady = s.flashReady;
    assign progFail = s.progFail;
    assign initDone = s.initDone;
    assign pins = s.pins;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence cmdStrobe;
        s.pins.cle && !s.pins.weN;
    endsequence

    a_busy_cmd_gate: assert property (@(posedge clk)
        disable iff (!nrst)
        (s.st == S_IDLE && reqValid && req.kind == 2'(nfh_pkg::NFH_CYC_CMD)
        && !ready_busy_n && !s.reqReady && !s.reqRefused
        && req.data != `NFH_CMD_STATUS && req.data != `NFH_CMD_STATUS_ALT
        && req.data != `NFH_CMD_RESET) |=> s.reqRefused)
        else $error("Command during busy was not refused");
    a_illegal_code_refused: assert property (@(posedge clk)
        disable iff (!nrst)
        (s.st == S_IDLE && reqValid && !s.reqReady && !s.reqRefused &&
        req.kind == 2'(nfh_pkg::NFH_CYC_CMD) && !legalCode)
        |=> s.reqRefused && s.st == S_IDLE)
        else $error("Undefined command was sent");
    a_prog_seq_gate: assert property (@(posedge clk)
        disable iff (!nrst)
        ($fell(s.pins.weN) && s.pins.cle && $past(s.inProgSeq, 2)) |->
        (s.pins.dataOut == `NFH_CMD_COL_CHANGE ||
        s.pins.dataOut == `NFH_CMD_PROG_CONF ||
        s.pins.dataOut == `NFH_CMD_MULTI_PROG ||
        s.pins.dataOut == `NFH_CMD_CACHE_PROG ||
        s.pins.dataOut == `NFH_CMD_RESET))
        else $error("Bad command after serial input");
    a_strobe_width: assert property (@(posedge clk)
        disable iff (!nrst)
        $fell(s.pins.weN) |-> !s.pins.weN [*5])
        else $error("Write strobe too short");
    a_init_window: assert property (@(posedge clk)
        disable iff (!nrst)
        (cmdStrobe and !s.initDone) |-> s.pins.dataOut == `NFH_CMD_RESET ||
        s.pins.dataOut == `NFH_CMD_STATUS ||
        s.pins.dataOut == `NFH_CMD_STATUS_ALT)
        else $error("Command other than reset or status before init");
    a_status_fail: assert property (@(posedge clk)
        disable iff (!nrst)
        (s.st == S_STROBE && s.cnt == 4'h0 && s.kind ==
        2'(nfh_pkg::NFH_CYC_RD) && s.lastStatus && dataIn[`NFH_ST_READY])
        |=> progFail == $past(dataIn[`NFH_ST_FAIL]))
        else $error("Pass/fail not captured when ready");
    a_wp_follow: assert property (@(posedge clk)
        disable iff (!nrst)
        1'b1 |=> pins.wpN == $past(writeProtectN))
        else $error("Write protect not forwarded");
    a_read_data: assert property (@(posedge clk)
        disable iff (!nrst)
        rdValid |-> $past(s.st) == S_STROBE ##1 !rdValid)
        else $error("Read data pulse malformed");
endmodule

// ### sim/nfh_flash_model.sv
// Behavioural flash device that answers the NAND host pins.
// Assumes the bench adds the busy line pull-up and routes the data port.
`timescale 1ns/1ns
`include "nfh_params.svh"

module nfh_flash_model #(
    parameter int BUSY_NS = 600
) (
    input wire nfh_pkg::nfh_pins_t pins,
    input wire logic strap,
    output logic busyDrive = 1'b1,
    output logic [7:0] dataOut = 8'h00
);
    time busyEnd = 0;
    logic statusMode = 1'b0;
    logic progOpen = 1'b0;
    logic fail = 1'b0;
    logic [7:0] col = 8'h00;
    logic [7:0] nextCol = 8'h00;
    int addrCnt = 0;

    // busy through power-up; strap high waits for reset
    initial begin
        #1;
        busyEnd = strap ? 64'hffff_ffff : BUSY_NS;
    end

    // open drain: only ever pulls the shared line low
    always #4 busyDrive = ($time < busyEnd);

    // command and address decode on write strobe
    always @(posedge pins.weN) begin
        if (!pins.ceN && pins.cle) begin
            case (pins.dataOut)
                `NFH_CMD_RESET: begin
                    statusMode = 1'b0;
                    progOpen = 1'b0;
                    busyEnd = $time + BUSY_NS;
                end
                `NFH_CMD_STATUS, `NFH_CMD_STATUS_ALT: statusMode = 1'b1;
                `NFH_CMD_READ: begin
                    if (statusMode) statusMode = 1'b0; // Column kept
                    else addrCnt = 0;
                end
                `NFH_CMD_READ_CONF: begin
                    col = nextCol;
                    busyEnd = $time + BUSY_NS;
                end
                `NFH_CMD_SERIAL_IN: begin
                    progOpen = 1'b1;
                    addrCnt = 0;
                end
                `NFH_CMD_COL_CHANGE: ;
                `NFH_CMD_PROG_CONF: begin
                    fail = progOpen && !pins.wpN;
                    if (progOpen) busyEnd = $time + BUSY_NS;
                    progOpen = 1'b0;
                end
                default: progOpen = 1'b0; // Pending program dropped
            endcase
        end else if (!pins.ceN && pins.ale) begin
            if (addrCnt == 0) nextCol = pins.dataOut; // Later bytes unused
            addrCnt++;
        end
    end

    // status byte or page byte while read strobe is low
    always @(negedge pins.reN) begin
        if (statusMode) dataOut = {pins.wpN, !busyDrive, !busyDrive, 4'h0, fail};
        else dataOut = col ^ 8'ha5;
    end

    // Released port shows the inverse of the last byte
    always @(posedge pins.reN) begin
        #1;
        if (!statusMode) col = col + 8'h01;
        dataOut = ~dataOut;
    end

    // write protect low aborts a running program
    always @(negedge pins.wpN) begin
        if ($time < busyEnd) begin
            busyEnd = $time;
            fail = 1'b1;
        end
    end
endmodule

// ### sim/nfh_host_test.sv
// Self-checking bench for the NAND host sequencer with a flash model.
// Assumes nfh_params.svh is on the include path.
`timescale 1ns/1ns
`include "nfh_params.svh"

module nfh_host_test;
    logic clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, writeProtectN = 1'b1;
    logic strap = 1'b1, reqReady, reqRefused, rdValid, flashReady;
    logic progFail, initDone, busyDrive, ready_busy_n;
    logic [7:0] rdData, flashData, c;
    nfh_pkg::nfh_req_t req = '0;
    nfh_pkg::nfh_pins_t pins;
    int mismatches = 0, cmp_count = 0;

    always #4 clk = ~clk;
    // pull-up on the shared busy line
    assign ready_busy_n = busyDrive ? 1'b0 : 1'b1;

    nfh_host dut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req),
        .writeProtectN(writeProtectN), .powerOnSelectStrap(strap),
        .ready_busy_n(ready_busy_n), .dataIn(flashData), .reqReady(reqReady),
        .reqRefused(reqRefused), .rdValid(rdValid), .rdData(rdData),
        .flashReady(flashReady), .progFail(progFail), .initDone(initDone),
        .pins(pins));
    nfh_flash_model flash (.pins(pins), .strap(strap),
        .busyDrive(busyDrive), .dataOut(flashData));

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One bus cycle; refusal and read byte compared with expectations
    task automatic op(input int k, input int d, input int expRef,
        input int expRd);
        int n;
        logic [7:0] got;
        got = ~8'(expRd);
        req.kind = 2'(k);
        req.data = 8'(d);
        reqValid = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (rdValid === 1'b1) got = rdData;
        end while (reqReady !== 1'b1 && reqRefused !== 1'b1 && n < 500);
        reqValid = 1'b0;
        check("answered", 8'(reqReady | reqRefused), 8'h01);
        check("refused", 8'(reqRefused), 8'(expRef));
        if (k == 3 && expRef == 0) check("rdData", got, 8'(expRd));
        // Let an edge pass so reqValid never falls and rises at once
        @(posedge clk);
        #1;
    endtask

    task automatic wait_ready;
        int n;
        for (n = 0; n < 400 && flashReady !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("flashReady", 8'(flashReady), 8'h01);
    endtask

    function automatic logic legal(input logic [7:0] v);
        case (v)
            `NFH_CMD_READ, `NFH_CMD_READ_CONF, `NFH_CMD_SERIAL_IN,
            `NFH_CMD_COL_CHANGE, `NFH_CMD_PROG_CONF, `NFH_CMD_MULTI_PROG,
            `NFH_CMD_CACHE_PROG, `NFH_CMD_ERASE1, `NFH_CMD_ERASE2,
            `NFH_CMD_STATUS, `NFH_CMD_STATUS_ALT, `NFH_CMD_RESET: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // program setup with a stray follow-up, then confirm
    task automatic program_page;
        op(0, `NFH_CMD_SERIAL_IN, 0, 0);
        repeat (5) op(1, $urandom, 0, 0);
        op(2, $urandom, 0, 0);
        op(0, `NFH_CMD_ERASE1, 1, 0);
        op(0, `NFH_CMD_PROG_CONF, 0, 0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hd635336b));
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        check("flashReady", 8'(flashReady), 8'h00);
        op(0, `NFH_CMD_SERIAL_IN, 1, 0);
        op(0, `NFH_CMD_STATUS, 0, 0);
        op(3, 0, 0, 8'h80);
        check("initDone", 8'(initDone), 8'h00);
        op(0, `NFH_CMD_RESET, 0, 0);
        wait_ready();
        @(posedge clk);
        #1 check("initDone", 8'(initDone), 8'h01);
        do c = 8'($urandom); while (legal(c));
        op(0, c, 1, 0);
        c = 8'($urandom);
        op(0, `NFH_CMD_READ, 0, 0);
        op(1, c, 0, 0);
        repeat (5) op(1, $urandom, 0, 0);
        op(0, `NFH_CMD_READ_CONF, 0, 0);
        op(0, `NFH_CMD_SERIAL_IN, 1, 0);
        op(0, `NFH_CMD_STATUS, 0, 0);
        op(3, 0, 0, 8'h80);
        wait_ready();
        op(3, 0, 0, 8'he0);
        op(0, `NFH_CMD_READ, 0, 0);
        op(3, 0, 0, c ^ 8'ha5);
        op(3, 0, 0, (c + 8'h01) ^ 8'ha5);
        op(0, `NFH_CMD_STATUS, 0, 0);
        op(3, 0, 0, 8'he0);
        op(0, `NFH_CMD_READ, 0, 0);
        op(3, 0, 0, (c + 8'h02) ^ 8'ha5);
        program_page();
        wait_ready();
        op(0, `NFH_CMD_STATUS, 0, 0);
        op(3, 0, 0, 8'he0);
        check("progFail", 8'(progFail), 8'h00);
        program_page();
        writeProtectN = 1'b0;
        repeat (12) @(posedge clk);
        #1 check("flashReady", 8'(flashReady), 8'h01);
        op(0, `NFH_CMD_STATUS, 0, 0);
        op(3, 0, 0, 8'h61);
        check("progFail", 8'(progFail), 8'h01);
        // Second reset with the strap low: init ends once line is ready
        strap = 1'b0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        check("initDone", 8'(initDone), 8'h00);
        @(posedge clk);
        #1 check("initDone", 8'(initDone), 8'h01);
        op(0, `NFH_CMD_STATUS_ALT, 0, 0);
        op(3, 0, 0, 8'h61);
        check("progFail", 8'(progFail), 8'h01);
        complete_run();
    end

    // Cuts a hang short
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
